// *** dram_cmd_consts.svh ***
// timing counts and first-edge opcodes for the command decoder
`ifndef DRAM_CMD_CONSTS_SVH
`define DRAM_CMD_CONSTS_SVH
`define CLK_PERIOD_PS        5000
`define CK_MIN_PULSE_PS      1000
`define CK_MIN_PULSE_CYC     ((`CK_MIN_PULSE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define XP_TIME_PS           7500
`define XP_TIME_CYC          ((`XP_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define XP_NCK               5
`define RECOVER_NCK          (2 + `XP_NCK)
`define RECOVER_TIME_CYC     `XP_TIME_CYC
`define CK_STOP_PS           400000
`define CK_STOP_CYC          (`CK_STOP_PS / `CLK_PERIOD_PS)
`define OP_MPC               5'h00
`define OP_PRE               5'h10
`define OP_REF               5'h08
`define OP_SRE               5'h18
`define OP_WR                5'h04
`define OP_SRX               5'h14
`define OP_MWR               5'h0c
`define OP_RD                5'h02
`define OP_CAS2              5'h12
`define OP_MRW1              5'h06
`define OP_MRW2              5'h16
`define OP_MRR               5'h0e
`endif

// *** dram_cmd_pkg.sv ***
// types for the command decoder
package dram_cmd_pkg;
    typedef enum logic [3:0] {
        CMD_DES  = 4'h0, CMD_MPC = 4'h1, CMD_PRE  = 4'h2, CMD_REF = 4'h3,
        CMD_SRE  = 4'h4, CMD_SRX = 4'h5, CMD_WR   = 4'h6, CMD_MWR = 4'h7,
        CMD_RD   = 4'h8, CMD_CAS2 = 4'h9, CMD_MRW1 = 4'ha, CMD_MRW2 = 4'hb,
        CMD_MRR  = 4'hc, CMD_ACT1 = 4'hd, CMD_ACT2 = 4'he, CMD_ILL = 4'hf
    } cmd_t;
    typedef struct packed {
        cmd_t       cmd;
        logic [2:0] bank;
        logic       all_bank_flag;
        logic       auto_precharge_flag;
        logic       burst_length_select;
        logic [9:0] column;
        logic [5:0] row_hi;
        logic [5:0] row_lo;
        logic [7:0] operand;
        logic [5:0] mode_addr;
    } decoded_t;
    typedef struct packed {
        logic       clk;
        logic       clock_gate;
        logic       cs;
        logic [5:0] command_address_bus;
    } pins_t;
endpackage

// *** ck_edge_sync.sv ***
`timescale 1ns/100ps
// synchroniser and edge finder for the command pins and the link clock
`include "dram_cmd_consts.svh"
module ck_edge_sync (
    input  wire logic                i_ref_clk,
    input  wire logic                i_nrst,
    input  wire dram_cmd_pkg::pins_t i_pins,
    output logic                     o_rise,
    output logic                     o_fall,
    output dram_cmd_pkg::pins_t      o_pins
);
    typedef struct packed {
        dram_cmd_pkg::pins_t s1;
        dram_cmd_pkg::pins_t s2;
        dram_cmd_pkg::pins_t s3;
    } state_t;
    state_t st_q;
    state_t st_d;
    always_comb begin
        st_d    = st_q;
        st_d.s1 = i_pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    // pins are sampled one stage behind so the edge sees settled command bits
    assign o_pins = st_q.s3;
    assign o_rise = st_q.s2.clk & ~st_q.s3.clk;
    assign o_fall = ~st_q.s2.clk & st_q.s3.clk;
endmodule

// *** dram_cmd_decode.sv ***
`timescale 1ns/100ps
// command decoder with clock stop detection and recovery; a frequency change with the clock running is not detected
// Summary of operation
// [R1] a delay ends only when both its time and its clock count have passed
// [R2] controller retunes clock with gate low only meeting minimum period, idle banks
// [R3] controller holds clock after gate low and gives valid clock before gate high
// [R4] controller may rewrite mode registers after a frequency change
// [R5] with gate low clock may stop; device ignores clock phases meanwhile
// [R6] gate-high retune: chip select low, all accesses finished, only refresh running
// [R7] after gate-high retune, ready after valid pulses for two clocks plus exit delay (code: ready drops only on a clock stop)
// [R8] gate-high stop: true clock low, complement high, chip select low
// [R9] controller finishes all commands then gives four more clocks before stop
// [R10] auto-precharge accesses need four extra clocks before stop
// [R11] refresh, self refresh and calibration start need four clocks before stop
// [R12] after gate-high stop, ready after restarted clock meets pulses for recovery delay
// [R13] undefined commands or timing are illegal and need reinitialisation
// [R14] clock gate stays high whenever a command is presented
// [R15] column second half: first edge L,H,L,L,H,C8; second edge C2..C7
// [R16] precharge and refresh: opcode, all-bank flag, bank on second edge
// [R17] commands take two edges identified on the first; deselect takes one
// [R18] mode-write and activate halves follow back to back in order
// [R19] first-edge opcodes decoded on bits 0..4 per command table
// [R20] reserved opcodes illegal; second-edge fields captured from table positions
`include "dram_cmd_consts.svh"
module dram_cmd_decode (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_clk_true,
    input  wire logic                   i_clock_gate_input,
    input  wire logic                   i_chip_select,
    input  wire logic [5:0]             i_command_address_bus,
    output logic                        o_cmd_valid,
    output dram_cmd_pkg::decoded_t      o_cmd,
    output logic                        o_illegal,
    output logic                        o_ready,
    output logic                        o_clock_stopped
);
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SECOND = 2'b01,
        PH_ACT2   = 2'b10,
        PH_MRW2   = 2'b11
    } phase_t;
    typedef struct packed {
        phase_t                 phase;
        dram_cmd_pkg::cmd_t     first_cmd;
        logic [5:0]             first_bits;
        logic                   valid;
        dram_cmd_pkg::decoded_t cmd;
        logic                   illegal;
        logic                   ready;
        logic [7:0]             nck_cnt;
        logic [7:0]             time_cnt;
        logic [7:0]             high_cnt;
        logic [7:0]             low_cnt;
        logic [16:0]            idle_cnt;
        logic                   stopped;
    } state_t;
    state_t              st_q;
    state_t              st_d;
    dram_cmd_pkg::pins_t pins_raw;
    dram_cmd_pkg::pins_t pins;
    logic                ck_rise;
    logic                ck_fall;
    logic                pulse_ok;
    dram_cmd_pkg::cmd_t  first_now;

    assign pins_raw = '{clk: i_clk_true, clock_gate: i_clock_gate_input,
                        cs: i_chip_select, command_address_bus: i_command_address_bus};

    ck_edge_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_pins    (pins_raw),
        .o_rise    (ck_rise),
        .o_fall    (ck_fall),
        .o_pins    (pins)
    );

    // bus bit 0 is the lsb of the five-bit opcode
    function automatic dram_cmd_pkg::cmd_t first_opcode(input logic [5:0] ca);
        logic [4:0] op;
        op = ca[4:0];
        first_opcode = dram_cmd_pkg::CMD_ILL; // R20
        if (ca[0] && !ca[1]) first_opcode = dram_cmd_pkg::CMD_ACT1; // R19
        else if (ca[0] && ca[1]) first_opcode = dram_cmd_pkg::CMD_ACT2; // R19
        else begin
            unique case (op)
                `OP_MPC:  first_opcode = dram_cmd_pkg::CMD_MPC;
                `OP_PRE:  first_opcode = dram_cmd_pkg::CMD_PRE; // R16
                `OP_REF:  first_opcode = dram_cmd_pkg::CMD_REF; // R16
                `OP_SRE:  first_opcode = dram_cmd_pkg::CMD_SRE;
                `OP_WR:   first_opcode = dram_cmd_pkg::CMD_WR;
                `OP_SRX:  first_opcode = dram_cmd_pkg::CMD_SRX;
                `OP_MWR:  first_opcode = ca[5] ? dram_cmd_pkg::CMD_ILL
                                               : dram_cmd_pkg::CMD_MWR;
                `OP_RD:   first_opcode = dram_cmd_pkg::CMD_RD;
                `OP_CAS2: first_opcode = dram_cmd_pkg::CMD_CAS2; // R15
                `OP_MRW1: first_opcode = dram_cmd_pkg::CMD_MRW1;
                `OP_MRW2: first_opcode = dram_cmd_pkg::CMD_MRW2;
                `OP_MRR:  first_opcode = dram_cmd_pkg::CMD_MRR;
                default:  first_opcode = dram_cmd_pkg::CMD_ILL; // R20
            endcase
        end
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hff) ? v : v + 8'h01;
    endfunction

    assign first_now = first_opcode(pins.command_address_bus);

    // both phases must have lasted the least pulse width
    assign pulse_ok = (st_q.high_cnt >= 8'(`CK_MIN_PULSE_CYC))
                    && (st_q.low_cnt >= 8'(`CK_MIN_PULSE_CYC));

    always_comb begin
        st_d       = st_q;
        st_d.valid = 1'b0;
        // pulse widths measured on the reference clock
        if (pins.clk) begin
            st_d.high_cnt = sat_inc(st_q.high_cnt);
        end
        if (!pins.clk) begin
            st_d.low_cnt = sat_inc(st_q.low_cnt);
        end
        // each count restarts as its own phase begins, so a rise sees both finished phases
        if (ck_rise) begin
            st_d.high_cnt = 8'h00;
        end
        if (ck_fall) begin
            st_d.low_cnt = 8'h00;
        end
        // a silent clock means a stop; ready drops until recovery
        if (ck_rise || ck_fall) begin
            st_d.idle_cnt = 17'h00000;
        end else if (st_q.idle_cnt != 17'(`CK_STOP_CYC)) begin
            st_d.idle_cnt = st_q.idle_cnt + 17'h00001;
        end
        if (st_q.idle_cnt == 17'(`CK_STOP_CYC)) begin
            st_d.stopped  = 1'b1; // R5 R8
            st_d.ready    = 1'b0;
            // a high phase from before the stop must not count for the restart
            st_d.high_cnt = 8'h00;
            st_d.nck_cnt  = 8'h00;
            st_d.time_cnt = 8'h00;
            st_d.phase    = PH_IDLE;
        end
        if (ck_rise) begin
            st_d.stopped = 1'b0;
        end
        // recovery needs both the cycle count and the absolute time
        if (!st_q.ready && !st_q.stopped) begin
            if (st_q.time_cnt != 8'hff) begin
                st_d.time_cnt = st_q.time_cnt + 8'h01;
            end
            if (ck_rise && pulse_ok) begin
                st_d.nck_cnt = sat_inc(st_q.nck_cnt); // R7 R12
            end else if (ck_rise) begin
                st_d.nck_cnt = 8'h00; // R7 R12
            end
            if (st_q.nck_cnt >= 8'(`RECOVER_NCK)
                && st_q.time_cnt >= 8'(`RECOVER_TIME_CYC)) begin
                st_d.ready = 1'b1; // R1
            end
        end
        // command decode on each rising edge of the link clock while ready and gated on
        if (ck_rise && st_q.ready && pins.clock_gate) begin
            unique case (st_q.phase)
                PH_IDLE, PH_ACT2, PH_MRW2: begin
                    if (pins.cs) begin
                        st_d.first_cmd  = first_now; // R17
                        // an activate or mode-write second half must follow its own first half and nothing else
                        if (((st_q.phase == PH_ACT2) != (first_now == dram_cmd_pkg::CMD_ACT2))
                            || ((st_q.phase == PH_MRW2)
                                != (first_now == dram_cmd_pkg::CMD_MRW2))) begin
                            st_d.first_cmd = dram_cmd_pkg::CMD_ILL; // R18
                        end
                        st_d.first_bits = pins.command_address_bus;
                        st_d.phase      = PH_SECOND;
                    end else begin
                        st_d.cmd.cmd = dram_cmd_pkg::CMD_DES; // R17
                        if (st_q.phase != PH_IDLE) begin
                            st_d.illegal = 1'b1; // R18
                            st_d.phase   = PH_IDLE;
                        end
                    end
                end
                PH_SECOND: begin
                    st_d.phase = PH_IDLE;
                    st_d.valid = 1'b1;
                    st_d.cmd.cmd = st_q.first_cmd;
                    // chip select high on a second edge breaks the two-edge frame
                    if (pins.cs) begin
                        st_d.cmd.cmd = dram_cmd_pkg::CMD_ILL; // R17
                    end
                    if (st_q.first_cmd == dram_cmd_pkg::CMD_ACT1) begin
                        st_d.phase = PH_ACT2; // R18
                    end
                    if (st_q.first_cmd == dram_cmd_pkg::CMD_MRW1) begin
                        st_d.phase = PH_MRW2; // R18
                    end
                    unique case (st_q.first_cmd)
                        dram_cmd_pkg::CMD_PRE, dram_cmd_pkg::CMD_REF: begin
                            st_d.cmd.all_bank_flag = st_q.first_bits[5]; // R16
                            st_d.cmd.bank = pins.command_address_bus[2:0]; // R16
                        end
                        dram_cmd_pkg::CMD_WR, dram_cmd_pkg::CMD_MWR,
                        dram_cmd_pkg::CMD_RD: begin
                            st_d.cmd.burst_length_select = st_q.first_bits[5]; // R20
                            st_d.cmd.bank = pins.command_address_bus[2:0];
                            st_d.cmd.column[9] = pins.command_address_bus[4];
                            st_d.cmd.auto_precharge_flag = pins.command_address_bus[5];
                        end
                        dram_cmd_pkg::CMD_CAS2: begin
                            st_d.cmd.column[8:0] = {st_q.first_bits[5],
                                pins.command_address_bus[5:0], 2'b00}; // R15
                        end
                        dram_cmd_pkg::CMD_ACT1: begin
                            st_d.cmd.bank = pins.command_address_bus[2:0]; // R20
                            st_d.cmd.row_hi = {st_q.first_bits[3:2],
                                pins.command_address_bus[5:4], 2'b00};
                        end
                        dram_cmd_pkg::CMD_ACT2: begin
                            st_d.cmd.row_lo = pins.command_address_bus;
                            st_d.cmd.row_hi[1:0] = st_q.first_bits[3:2];
                            st_d.cmd.operand[3:0] = st_q.first_bits[5:2];
                        end
                        dram_cmd_pkg::CMD_MPC: begin
                            st_d.cmd.operand = {1'b0, st_q.first_bits[5],
                                pins.command_address_bus}; // R20
                        end
                        dram_cmd_pkg::CMD_MRW2: begin
                            // keeps the top operand bit that the first half carried
                            st_d.cmd.operand[6:0] = {st_q.first_bits[5],
                                pins.command_address_bus}; // R20
                        end
                        dram_cmd_pkg::CMD_MRW1: begin
                            st_d.cmd.operand[7] = st_q.first_bits[5];
                            st_d.cmd.mode_addr = pins.command_address_bus;
                        end
                        dram_cmd_pkg::CMD_MRR: begin
                            st_d.cmd.mode_addr = pins.command_address_bus;
                        end
                        default: begin
                            st_d.cmd.bank = st_q.cmd.bank;
                        end
                    endcase
                end
            endcase
        end
        // sticky until reset: only reinitialisation clears an illegal event
        if (st_d.valid && st_d.cmd.cmd == dram_cmd_pkg::CMD_ILL) begin
            st_d.illegal = 1'b1; // R13
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_cmd_valid     = st_q.valid;
    assign o_cmd           = st_q.cmd;
    assign o_illegal       = st_q.illegal;
    assign o_ready         = st_q.ready;
    assign o_clock_stopped = st_q.stopped;
endmodule

// *** dram_cmd_decode_chk.sv ***
`timescale 1ns/100ps
// port assertions for the command decoder
`include "dram_cmd_consts.svh"
module dram_cmd_decode_chk (
    input wire logic                   i_ref_clk,
    input wire logic                   i_nrst,
    input wire logic                   i_clk_true,
    input wire logic                   i_clock_gate_input,
    input wire logic                   i_chip_select,
    input wire logic [5:0]             i_command_address_bus,
    input wire logic                   o_cmd_valid,
    input wire dram_cmd_pkg::decoded_t o_cmd,
    input wire logic                   o_illegal,
    input wire logic                   o_ready,
    input wire logic                   o_clock_stopped
);
    // sync delay of a few cycles is allowed for
    localparam int STOP_MIN = `CK_STOP_CYC - 8;
    logic [3:0]  rises_q;
    logic [16:0] quiet_q;
    logic        last_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rises_q <= 4'h0;
            quiet_q <= 17'h0;
            last_q  <= 1'b0;
        end else begin
            last_q <= i_clk_true;
            if (o_ready)
                rises_q <= 4'h0;
            else if (i_clk_true && !last_q && rises_q != 4'hf)
                rises_q <= rises_q + 4'h1;
            if (i_clk_true != last_q)
                quiet_q <= 17'h0;
            else if (quiet_q != 17'h1ffff)
                quiet_q <= quiet_q + 17'h1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence gate_low_run;
        !i_clock_gate_input [*8];
    endsequence
    sequence link_rise_stopped;
        $rose(i_clk_true) && o_clock_stopped;
    endsequence
    valid_pulse_a: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("valid longer than one cycle");
    illegal_sticky_a: assert property (o_illegal |=> o_illegal)
        else $error("illegal flag dropped");
    valid_ready_a: assert property (o_cmd_valid |-> o_ready)
        else $error("command decoded while not ready");
    stop_ready_a: assert property (o_clock_stopped |-> !o_ready)
        else $error("ready while clock stopped");
    gate_ignore_a: assert property (gate_low_run |=> !o_cmd_valid)
        else $error("command decoded with gate low");
    ready_count_a: assert property ($rose(o_ready) |-> rises_q >= 4'h7)
        else $error("ready before seven link edges");
    stop_quiet_a: assert property ($rose(o_clock_stopped) |-> quiet_q >= STOP_MIN)
        else $error("stop flagged too early");
    edge_wakes_a: assert property (link_rise_stopped |-> ##[1:8] !o_clock_stopped)
        else $error("stop flag kept after edge");
endmodule
bind dram_cmd_decode dram_cmd_decode_chk chk_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_clk_true(i_clk_true), .i_clock_gate_input(i_clock_gate_input),
    .i_chip_select(i_chip_select), .i_command_address_bus(i_command_address_bus),
    .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_illegal(o_illegal),
    .o_ready(o_ready), .o_clock_stopped(o_clock_stopped));

// *** dram_ctrl_model.sv ***
`timescale 1ns/100ps
// controller model driving link clock, gate, chip select and command bus
module dram_ctrl_model (
    input  wire logic  i_ref_clk,
    output logic       o_clk_true,
    output logic       o_gate,
    output logic       o_cs,
    output logic [5:0] o_bus
);
    initial begin
        o_clk_true = 1'b0;
        o_gate     = 1'b1;
        o_cs       = 1'b0;
        o_bus      = 6'h2a;
    end
    // one 125 ns link period; clock parks low between ticks
    task automatic tick(input logic cs, input logic [5:0] bus);
        @(negedge i_ref_clk);
        o_cs  = cs;
        o_bus = bus;
        repeat (12) @(negedge i_ref_clk);
        o_clk_true = 1'b1;
        repeat (12) @(negedge i_ref_clk);
        o_clk_true = 1'b0;
        o_bus      = ~bus;
    endtask
    task automatic send(input logic [5:0] first, input logic [5:0] second);
        tick(1'b1, first);
        tick(1'b0, second);
    endtask
    // chip select low and only idle edges: the stop and retune preconditions
    task automatic idle(input int n);
        repeat (n) tick(1'b0, ~o_bus);
    endtask
    task automatic gate(input logic v);
        idle(5);
        @(negedge i_ref_clk);
        o_gate = v;
        idle(5);
    endtask
endmodule

// *** dram_cmd_decode_clock_change_bench.sv ***
`timescale 1ns/100ps
// self-checking bench for the command decoder
`include "dram_cmd_consts.svh"
module dram_cmd_decode_clock_change_bench;
    logic                   ref_clk;
    logic                   nrst = 1'b0;
    logic                   clk_true;
    logic                   gate;
    logic                   cs;
    logic [5:0]             bus;
    logic                   valid;
    logic                   illegal;
    logic                   ready;
    logic                   stopped;
    dram_cmd_pkg::decoded_t cmd;
    dram_cmd_pkg::decoded_t last;
    int                     n_valid = 0;
    int                     n_mismatch = 0;
    int                     compares = 0;
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    dram_ctrl_model dram_ctrl_model_i (
        .i_ref_clk  (ref_clk),
        .o_clk_true (clk_true),
        .o_gate     (gate),
        .o_cs       (cs),
        .o_bus      (bus)
    );
    dram_cmd_decode dram_cmd_decode_i (
        .i_ref_clk             (ref_clk),
        .i_nrst                (nrst),
        .i_clk_true            (clk_true),
        .i_clock_gate_input    (gate),
        .i_chip_select         (cs),
        .i_command_address_bus (bus),
        .o_cmd_valid           (valid),
        .o_cmd                 (cmd),
        .o_illegal             (illegal),
        .o_ready               (ready),
        .o_clock_stopped       (stopped)
    );
    // mid-cycle sampling so the one-cycle pulse is never missed
    always @(negedge ref_clk) begin
        if (valid === 1'b1) begin
            n_valid++;
            last = cmd;
        end
    end
    task automatic results;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        n_mismatch++;
        $display("FAIL %0t %s", $time, msg);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) fail(msg);
    endtask
    task automatic chk_cmd(input dram_cmd_pkg::cmd_t exp);
        compares++;
        if (last.cmd !== exp) fail("wrong command");
    endtask
    task automatic chk_field(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) fail("wrong field");
    endtask
    task automatic chk_count(input int exp);
        compares++;
        if (n_valid != exp) fail("wrong pulse count");
    endtask
    task automatic do_reset;
        nrst = 1'b0;
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
    endtask
    task automatic one(input logic [5:0] f, input logic [5:0] s, input dram_cmd_pkg::cmd_t exp);
        int nv;
        nv = n_valid;
        dram_ctrl_model_i.send(f, s);
        repeat (4) @(negedge ref_clk);
        chk_count(nv + 1);
        chk_cmd(exp);
    endtask
    task automatic t_recover;
        do_reset();
        chk_bit(ready, 1'b0, "ready in reset");
        chk_bit(illegal, 1'b0, "illegal in reset");
        dram_ctrl_model_i.idle(3);
        chk_bit(ready, 1'b0, "ready too early");
        dram_ctrl_model_i.idle(5);
        chk_bit(ready, 1'b1, "not ready");
    endtask
    task automatic t_decode;
        one(6'h20, 6'h15, dram_cmd_pkg::CMD_MPC);
        one(6'h10, 6'h05, dram_cmd_pkg::CMD_PRE);
        chk_field(10'(last.bank), 10'h005);
        one(6'h28, 6'h02, dram_cmd_pkg::CMD_REF);
        chk_field(10'(last.all_bank_flag), 10'h001);
        one(6'h18, 6'h00, dram_cmd_pkg::CMD_SRE);
        one(6'h14, 6'h00, dram_cmd_pkg::CMD_SRX);
        one(6'h04, 6'h03, dram_cmd_pkg::CMD_WR);
        one(6'h32, 6'h2c, dram_cmd_pkg::CMD_CAS2);
        chk_field({1'b0, last.column[8:0]}, 10'h1b0);
        one(6'h22, 6'h23, dram_cmd_pkg::CMD_RD);
        chk_field({last.auto_precharge_flag, last.burst_length_select,
                   last.bank, 5'h00}, 10'h360);
        one(6'h12, 6'h01, dram_cmd_pkg::CMD_CAS2);
        one(6'h0c, 6'h00, dram_cmd_pkg::CMD_MWR);
        one(6'h12, 6'h00, dram_cmd_pkg::CMD_CAS2);
        one(6'h0e, 6'h07, dram_cmd_pkg::CMD_MRR);
        one(6'h12, 6'h00, dram_cmd_pkg::CMD_CAS2);
        one(6'h06, 6'h11, dram_cmd_pkg::CMD_MRW1);
        chk_field(10'(last.mode_addr), 10'h011);
        one(6'h16, 6'h05, dram_cmd_pkg::CMD_MRW2);
        one(6'h01, 6'h04, dram_cmd_pkg::CMD_ACT1);
        one(6'h03, 6'h2a, dram_cmd_pkg::CMD_ACT2);
        chk_field(10'(last.row_lo), 10'h02a);
        chk_bit(illegal, 1'b0, "legal command flagged");
    endtask
    task automatic t_gate;
        int nv;
        dram_ctrl_model_i.gate(1'b0);
        nv = n_valid;
        dram_ctrl_model_i.send(6'h10, 6'h01);
        repeat (4) @(negedge ref_clk);
        chk_count(nv);
        dram_ctrl_model_i.gate(1'b1);
        dram_ctrl_model_i.idle(8);
        one(6'h10, 6'h02, dram_cmd_pkg::CMD_PRE);
    endtask
    task automatic t_stop;
        dram_ctrl_model_i.idle(4);
        repeat (`CK_STOP_CYC + 20) @(negedge ref_clk);
        chk_bit(stopped, 1'b1, "stop not seen");
        chk_bit(ready, 1'b0, "ready while stopped");
        dram_ctrl_model_i.idle(3);
        chk_bit(stopped, 1'b0, "stop kept");
        chk_bit(ready, 1'b0, "ready too soon");
        dram_ctrl_model_i.idle(5);
        chk_bit(ready, 1'b1, "not ready after restart");
        one(6'h28, 6'h00, dram_cmd_pkg::CMD_REF);
        one(6'h26, 6'h02, dram_cmd_pkg::CMD_MRW1);
        one(6'h36, 6'h05, dram_cmd_pkg::CMD_MRW2);
        chk_field(10'(last.operand), 10'h0c5);
    endtask
    task automatic t_illegal;
        dram_ctrl_model_i.send(6'h1c, 6'h00);
        dram_ctrl_model_i.idle(1);
        chk_bit(illegal, 1'b1, "reserved opcode taken");
        dram_ctrl_model_i.send(6'h10, 6'h00);
        chk_bit(illegal, 1'b1, "illegal flag cleared");
        do_reset();
        chk_bit(illegal, 1'b0, "illegal after reset");
        dram_ctrl_model_i.idle(8);
        dram_ctrl_model_i.send(6'h01, 6'h00);
        dram_ctrl_model_i.send(6'h10, 6'h00);
        dram_ctrl_model_i.idle(1);
        chk_bit(illegal, 1'b1, "split activate taken");
    endtask
    initial begin
        t_recover();
        t_decode();
        t_gate();
        t_stop();
        t_illegal();
        results();
    end
    // link ticks dominate the run time; the stop span is only 500 ns
    initial begin
        #480000;
        fail("watchdog");
        results();
    end
endmodule
